// >>> pkg/sba_defs.svh
// register offsets, field positions and reset values of the spectral alarm unit
// assumes byte-addressed 16-bit registers reached by the serial register port
`ifndef SBA_DEFS_SVH
`define SBA_DEFS_SVH

`define SBA_OFS_F_LOW 7'h20
`define SBA_OFS_F_HIGH 7'h22
`define SBA_OFS_X_WARN 7'h24
`define SBA_OFS_Y_WARN 7'h26
`define SBA_OFS_Z_WARN 7'h28
`define SBA_OFS_X_FAULT 7'h2a
`define SBA_OFS_Y_FAULT 7'h2c
`define SBA_OFS_Z_FAULT 7'h2e
`define SBA_OFS_PNTR 7'h30
`define SBA_OFS_SYS_LVL 7'h32
`define SBA_OFS_CFG 7'h34
`define SBA_OFS_DIAG 7'h3c
`define SBA_OFS_X_STAT 7'h40
`define SBA_OFS_Y_STAT 7'h42
`define SBA_OFS_Z_STAT 7'h44
`define SBA_OFS_X_PEAK 7'h46
`define SBA_OFS_Y_PEAK 7'h48
`define SBA_OFS_Z_PEAK 7'h4a
`define SBA_OFS_X_BIN 7'h70
`define SBA_OFS_Y_BIN 7'h72
`define SBA_OFS_Z_BIN 7'h74

`define SBA_CFG_RST 16'h0080
`define SBA_CFG_DELAY_HI 11
`define SBA_CFG_DELAY_LO 8
`define SBA_CFG_LATCH 7
`define SBA_CFG_AUX 6
`define SBA_CFG_SYS_POL 5
`define SBA_CFG_SYS_SRC 4
`define SBA_CFG_SYS_EN 3
`define SBA_CFG_AXIS_EN_LO 0

`define SBA_PNTR_BAND_HI 2
`define SBA_PNTR_RATE_HI 9
`define SBA_PNTR_RATE_LO 8
`define SBA_SYS_LVL_HI 11

`define SBA_DIAG_ALM_LO 8
`define SBA_NBANDS 6
`define SBA_NRATES 4
`define SBA_NAXES 3
`define SBA_CNT_MAX 5'h10

`endif

// >>> pkg/sba_pkg.sv
// types shared by the spectral alarm unit and its surroundings
// assumes the FFT engine presents one bin of all three axes per cycle
package sba_pkg;

    // one FFT bin of all three axes, axis 0 = x
    typedef struct packed {
        logic [7:0] index;
        logic [2:0][15:0] mag;
    } sba_bin_t;

    // one-cycle command strobes decoded from the global command register
    typedef struct packed {
        logic clear_status;
        logic clear_settings;
        logic save_settings;
    } sba_cmd_t;

    // system measurement samples
    typedef struct packed {
        logic valid;
        logic [11:0] temp;
        logic [11:0] supply;
    } sba_meas_t;

endpackage : sba_pkg

// >>> hdl/sba_alarm_unit.sv
// spectral band alarm unit: limits, thresholds, record evaluation and status
// assumes record, bin, measurement and command strobes come from sys_clk logic
`timescale 1ns/1ps
`include "sba_defs.svh"

module sba_alarm_unit (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port, byte writes and word reads
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [15:0] reg_rd_data,
    // fft record stream
    input wire logic rec_start,
    input wire logic rec_end,
    input wire logic bin_valid,
    input wire sba_pkg::sba_bin_t bin_in,
    input wire logic [1:0] active_rate,
    // system measurement and commands
    input wire sba_pkg::sba_meas_t meas_in,
    input wire sba_pkg::sba_cmd_t cmd_in,
    // alarm indicators
    output logic aux_output_one,
    output logic aux_output_two,
    output logic record_alarm
);
    import sba_pkg::*;

    localparam int NB = `SBA_NBANDS;
    localparam int NA = `SBA_NAXES;
    localparam int NL = `SBA_NBANDS * `SBA_NRATES;

    // configuration registers
    logic [15:0] cfg_reg;
    logic [2:0] band_ptr_reg;
    logic [1:0] rate_ptr_reg;
    logic [NA-1:0][15:0] warn_lvl_reg;
    logic [NA-1:0][15:0] fault_lvl_reg;
    logic [15:0] sys_lvl_reg;
    // band limits: staged by host, active after save
    logic [7:0] stage_lo [NL];
    logic [7:0] stage_hi [NL];
    logic [7:0] act_lo [NL];
    logic [7:0] act_hi [NL];
    logic locked_reg;
    // evaluation state
    logic [NA-1:0][NB-1:0] warn_hit_reg;
    logic [NA-1:0][NB-1:0] fault_hit_reg;
    logic [NA-1:0][NB-1:0] warn_flag_reg;
    logic [NA-1:0][NB-1:0] fault_flag_reg;
    logic [NA-1:0][NB-1:0] warn_flag_next;
    logic [NA-1:0][NB-1:0] fault_flag_next;
    logic [NA-1:0][NB-1:0] warn_now;
    logic [NA-1:0][NB-1:0] fault_now;
    logic [NA-1:0][15:0] run_peak_reg;
    logic [NA-1:0][7:0] run_bin_reg;
    logic [NA-1:0][15:0] peak_reg;
    logic [NA-1:0][7:0] peak_bin_reg;
    logic sys_alarm_reg;
    logic [3:0] diag_reg;
    logic [3:0] alarm_cur;

    // decoded write strobes
    logic [6:0] word_addr;
    logic wr_lo;
    logic wr_hi;
    logic ptr_ok;
    logic [4:0] ptr_idx;
    logic [3:0] delay;
    logic [NA-1:0] axis_en;

    assign word_addr = {reg_addr[6:1], 1'b0};
    assign wr_lo = reg_wr_en && !reg_addr[0];
    assign wr_hi = reg_wr_en && reg_addr[0];
    assign ptr_ok = (band_ptr_reg >= 3'h1) && (band_ptr_reg <= 3'h6);
    assign ptr_idx = 5'(rate_ptr_reg * NB + band_ptr_reg - 3'h1);
    assign delay = cfg_reg[`SBA_CFG_DELAY_HI:`SBA_CFG_DELAY_LO];
    assign axis_en = cfg_reg[`SBA_CFG_AXIS_EN_LO +: NA];

    // byte merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic hi, input logic [7:0] d);
        merge = hi ? {d, old[7:0]} : {old[15:8], d};
    endfunction : merge

    // alarm configuration and pointer registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= `SBA_CFG_RST;
            band_ptr_reg <= 3'h0;
            rate_ptr_reg <= 2'h0;
            sys_lvl_reg <= 16'h0000;
        end else if (reg_wr_en) begin
            if (word_addr == `SBA_OFS_CFG) begin
                cfg_reg <= merge(cfg_reg, reg_addr[0], reg_wr_data) & 16'h0fff;
            end
            if (word_addr == `SBA_OFS_SYS_LVL) begin
                sys_lvl_reg <= merge(sys_lvl_reg, reg_addr[0], reg_wr_data);
            end
            if (reg_addr == `SBA_OFS_PNTR) begin
                band_ptr_reg <= reg_wr_data[`SBA_PNTR_BAND_HI:0];
            end
            if (wr_hi && word_addr == `SBA_OFS_PNTR) begin
                rate_ptr_reg <= reg_wr_data[`SBA_PNTR_RATE_HI-8:`SBA_PNTR_RATE_LO-8];
            end
        end
    end

    // per-axis warning and fault thresholds
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            warn_lvl_reg <= '0;
            fault_lvl_reg <= '0;
        end else if (reg_wr_en) begin
            for (int a = 0; a < NA; a++) begin
                if (word_addr == 7'(`SBA_OFS_X_WARN + 2 * a)) begin
                    warn_lvl_reg[a] <= merge(warn_lvl_reg[a], reg_addr[0], reg_wr_data);
                end
                if (word_addr == 7'(`SBA_OFS_X_FAULT + 2 * a)) begin
                    fault_lvl_reg[a] <= merge(fault_lvl_reg[a], reg_addr[0], reg_wr_data);
                end
            end
        end
    end

    // band limit staging, save and clear of the active set
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NL; i++) begin
                stage_lo[i] <= 8'h00;
                stage_hi[i] <= 8'h00;
                act_lo[i] <= 8'h00;
                act_hi[i] <= 8'h00;
            end
            locked_reg <= 1'b0;
        end else if (cmd_in.clear_settings) begin
            for (int i = 0; i < NL; i++) begin
                stage_lo[i] <= 8'h00;
                stage_hi[i] <= 8'h00;
                act_lo[i] <= 8'h00;
                act_hi[i] <= 8'h00;
            end
            locked_reg <= 1'b0;
        end else begin
            if (wr_lo && ptr_ok && reg_addr == `SBA_OFS_F_LOW) begin
                stage_lo[ptr_idx] <= reg_wr_data;
            end
            if (wr_lo && ptr_ok && reg_addr == `SBA_OFS_F_HIGH) begin
                stage_hi[ptr_idx] <= reg_wr_data;
            end
            if (cmd_in.save_settings && !locked_reg) begin
                act_lo <= stage_lo;
                act_hi <= stage_hi;
                locked_reg <= 1'b1;
            end
        end
    end

    // per axis and band comparison, delay counting and flags
    for (genvar a = 0; a < NA; a++) begin : g_axis
        for (genvar b = 0; b < NB; b++) begin : g_band
            logic [4:0] li;
            logic in_band;
            logic [4:0] cnt_w_reg;
            logic [4:0] cnt_f_reg;
            logic [4:0] cnt_w_next;
            logic [4:0] cnt_f_next;
            logic w_rec;
            logic f_rec;

            assign li = 5'(active_rate * NB + b);
            assign in_band = (bin_in.index >= act_lo[li]) && (bin_in.index <= act_hi[li]);
            assign warn_now[a][b] = bin_valid && axis_en[a] && in_band
                && (bin_in.mag[a] > warn_lvl_reg[a]);
            assign fault_now[a][b] = bin_valid && axis_en[a] && in_band
                && (bin_in.mag[a] > fault_lvl_reg[a]);
            assign w_rec = warn_hit_reg[a][b] && axis_en[a];
            assign f_rec = fault_hit_reg[a][b] && axis_en[a];
            // consecutive record count saturates above the largest delay
            assign cnt_w_next = !w_rec ? 5'h00 : (cnt_w_reg == `SBA_CNT_MAX) ? cnt_w_reg : cnt_w_reg + 5'h01;
            assign cnt_f_next = !f_rec ? 5'h00 : (cnt_f_reg == `SBA_CNT_MAX) ? cnt_f_reg : cnt_f_reg + 5'h01;
            assign warn_flag_next[a][b] = w_rec && (cnt_w_next > {1'b0, delay});
            assign fault_flag_next[a][b] = f_rec && (cnt_f_next > {1'b0, delay});

            // accumulate hits across the bins of one record
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    warn_hit_reg[a][b] <= 1'b0;
                    fault_hit_reg[a][b] <= 1'b0;
                end else if (rec_start) begin
                    warn_hit_reg[a][b] <= 1'b0;
                    fault_hit_reg[a][b] <= 1'b0;
                end else begin
                    warn_hit_reg[a][b] <= warn_hit_reg[a][b] | warn_now[a][b];
                    fault_hit_reg[a][b] <= fault_hit_reg[a][b] | fault_now[a][b];
                end
            end

            // counters and flags advance once per record
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    cnt_w_reg <= 5'h00;
                    cnt_f_reg <= 5'h00;
                    warn_flag_reg[a][b] <= 1'b0;
                    fault_flag_reg[a][b] <= 1'b0;
                end else if (rec_end) begin
                    cnt_w_reg <= cnt_w_next;
                    cnt_f_reg <= cnt_f_next;
                    warn_flag_reg[a][b] <= warn_flag_next[a][b];
                    fault_flag_reg[a][b] <= fault_flag_next[a][b];
                end
            end
        end

        // worst alarm peak and its bin within the running record
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                run_peak_reg[a] <= 16'h0000;
                run_bin_reg[a] <= 8'h00;
                peak_reg[a] <= 16'h0000;
                peak_bin_reg[a] <= 8'h00;
            end else if (rec_start) begin
                run_peak_reg[a] <= 16'h0000;
                run_bin_reg[a] <= 8'h00;
            end else if (rec_end) begin
                peak_reg[a] <= run_peak_reg[a];
                peak_bin_reg[a] <= run_bin_reg[a];
            end else if (|warn_now[a] && bin_in.mag[a] > run_peak_reg[a]) begin
                run_peak_reg[a] <= bin_in.mag[a];
                run_bin_reg[a] <= bin_in.index;
            end
        end
    end

    // status word: fault/warn pair per band, most critical band below
    function automatic logic [15:0] status_word(input logic [NB-1:0] w, input logic [NB-1:0] f);
        logic [2:0] crit;
        crit = 3'h0;
        for (int b = NB - 1; b >= 0; b--) begin
            if (w[b] && !(|f)) begin
                crit = 3'(b + 1);
            end
        end
        for (int b = NB - 1; b >= 0; b--) begin
            if (f[b]) begin
                crit = 3'(b + 1);
            end
        end
        status_word = 16'h0000;
        for (int b = 0; b < NB; b++) begin
            status_word[4 + 2 * b] = w[b];
            status_word[5 + 2 * b] = f[b];
        end
        status_word[2:0] = crit;
    endfunction : status_word

    // system alarm on temperature or supply against the 12-bit level
    logic [11:0] sys_meas;
    assign sys_meas = cfg_reg[`SBA_CFG_SYS_SRC] ? meas_in.temp : meas_in.supply;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sys_alarm_reg <= 1'b0;
        end else if (!cfg_reg[`SBA_CFG_SYS_EN]) begin
            sys_alarm_reg <= 1'b0;
        end else if (meas_in.valid) begin
            sys_alarm_reg <= cfg_reg[`SBA_CFG_SYS_POL] ? (sys_meas < sys_lvl_reg[`SBA_SYS_LVL_HI:0])
                : (sys_meas > sys_lvl_reg[`SBA_SYS_LVL_HI:0]);
        end
    end

    // diagnostic alarm flags, live or latched until clear-status
    assign alarm_cur = {sys_alarm_reg, |(warn_flag_reg[2] | fault_flag_reg[2]),
        |(warn_flag_reg[1] | fault_flag_reg[1]), |(warn_flag_reg[0] | fault_flag_reg[0])};
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            diag_reg <= 4'h0;
        end else if (!cfg_reg[`SBA_CFG_LATCH] || cmd_in.clear_status) begin
            diag_reg <= alarm_cur;
        end else begin
            diag_reg <= diag_reg | alarm_cur;
        end
    end

    // alarm indicator outputs and record alarm pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aux_output_one <= 1'b0;
            aux_output_two <= 1'b0;
            record_alarm <= 1'b0;
        end else begin
            aux_output_one <= cfg_reg[`SBA_CFG_AUX] && (|warn_flag_reg);
            aux_output_two <= cfg_reg[`SBA_CFG_AUX] && (|fault_flag_reg);
            record_alarm <= rec_end && (|warn_flag_next || |fault_flag_next);
        end
    end

    // register read mux, unmapped words read zero
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (word_addr)
            `SBA_OFS_F_LOW: rd_mux = ptr_ok ? {8'h00, stage_lo[ptr_idx]} : 16'h0000;
            `SBA_OFS_F_HIGH: rd_mux = ptr_ok ? {8'h00, stage_hi[ptr_idx]} : 16'h0000;
            `SBA_OFS_X_WARN: rd_mux = warn_lvl_reg[0];
            `SBA_OFS_Y_WARN: rd_mux = warn_lvl_reg[1];
            `SBA_OFS_Z_WARN: rd_mux = warn_lvl_reg[2];
            `SBA_OFS_X_FAULT: rd_mux = fault_lvl_reg[0];
            `SBA_OFS_Y_FAULT: rd_mux = fault_lvl_reg[1];
            `SBA_OFS_Z_FAULT: rd_mux = fault_lvl_reg[2];
            `SBA_OFS_PNTR: rd_mux = {6'h00, rate_ptr_reg, 5'h00, band_ptr_reg};
            `SBA_OFS_SYS_LVL: rd_mux = sys_lvl_reg;
            `SBA_OFS_CFG: rd_mux = cfg_reg;
            `SBA_OFS_DIAG: rd_mux = 16'(diag_reg) << `SBA_DIAG_ALM_LO;
            `SBA_OFS_X_STAT: rd_mux = status_word(warn_flag_reg[0], fault_flag_reg[0]);
            `SBA_OFS_Y_STAT: rd_mux = status_word(warn_flag_reg[1], fault_flag_reg[1]);
            `SBA_OFS_Z_STAT: rd_mux = status_word(warn_flag_reg[2], fault_flag_reg[2]);
            `SBA_OFS_X_PEAK: rd_mux = peak_reg[0];
            `SBA_OFS_Y_PEAK: rd_mux = peak_reg[1];
            `SBA_OFS_Z_PEAK: rd_mux = peak_reg[2];
            `SBA_OFS_X_BIN: rd_mux = {8'h00, peak_bin_reg[0]};
            `SBA_OFS_Y_BIN: rd_mux = {8'h00, peak_bin_reg[1]};
            `SBA_OFS_Z_BIN: rd_mux = {8'h00, peak_bin_reg[2]};
            default: rd_mux = 16'h0000;
        endcase
    end

    // read data is registered, one cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rd_data <= 16'h0000;
        end else if (reg_rd_en) begin
            reg_rd_data <= rd_mux;
        end
    end

endmodule : sba_alarm_unit

// >>> dv/sba_alarm_unit_asserts.sv
// port-level checker for the spectral band alarm unit
// assumes the register offsets of sba_defs.svh; attached to the unit by bind
`timescale 1ns/1ps
`include "sba_defs.svh"

module sba_alarm_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [15:0] reg_rd_data,
    // record stream
    input wire logic rec_start,
    input wire logic rec_end,
    input wire logic bin_valid,
    input wire sba_pkg::sba_bin_t bin_in,
    input wire logic [1:0] active_rate,
    // measurement and commands
    input wire sba_pkg::sba_meas_t meas_in,
    input wire sba_pkg::sba_cmd_t cmd_in,
    // indicators
    input wire logic aux_output_one,
    input wire logic aux_output_two,
    input wire logic record_alarm
);
    import sba_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // word being read, parked on an unmapped word when idle
    logic [5:0] rw;
    assign rw = reg_rd_en ? reg_addr[6:1] : 6'h3f;

    a_cfg_top_zero: assert property (rw == (`SBA_OFS_CFG >> 1) |=> reg_rd_data[15:12] == 4'h0)
        else $error("config read shows unused bits");
    a_pntr_unused_zero: assert property (rw == (`SBA_OFS_PNTR >> 1) |=> reg_rd_data[15:10] == 6'h00 && reg_rd_data[7:3] == 5'h00)
        else $error("pointer read shows unused bits");
    a_limit_bin_only: assert property ((rw == (`SBA_OFS_F_LOW >> 1)) || (rw == (`SBA_OFS_F_HIGH >> 1)) |=> reg_rd_data[15:8] == 8'h00)
        else $error("limit read wider than a bin");
    a_stat_band_field: assert property (rw >= (`SBA_OFS_X_STAT >> 1) && rw <= (`SBA_OFS_Z_STAT >> 1) |=> !reg_rd_data[3] && reg_rd_data[2:0] <= 3'd6 && ((reg_rd_data[15:4] == 12'h000) == (reg_rd_data[2:0] == 3'd0)))
        else $error("status band field inconsistent");
    a_peak_bin_width: assert property (rw >= (`SBA_OFS_X_BIN >> 1) && rw <= (`SBA_OFS_Z_BIN >> 1) |=> reg_rd_data[15:8] == 8'h00)
        else $error("peak bin wider than a bin");
    a_rd_data_holds: assert property (!reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without a read");
    a_alarm_after_end: assert property (record_alarm |-> $past(rec_end))
        else $error("record alarm without record end");
    a_alarm_single: assert property (record_alarm |=> !record_alarm)
        else $error("record alarm longer than one cycle");
    a_aux_moves_late: assert property ($changed(aux_output_one) || $changed(aux_output_two) |-> $past(rec_end, 2) || $past(reg_wr_en) || $past(reg_wr_en, 2) || $past(cmd_in) != 3'b000)
        else $error("indicator moved without a cause");
    a_diag_unused_zero: assert property (rw == (`SBA_OFS_DIAG >> 1) |=> reg_rd_data[7:0] == 8'h00 && reg_rd_data[15:12] == 4'h0)
        else $error("diagnostic read shows unused bits");

    // main scenarios reached
    c_alarm_pulse: cover property (record_alarm);
    c_fault_out: cover property ($rose(aux_output_two));
    c_status_read: cover property (rw == (`SBA_OFS_X_STAT >> 1) ##1 reg_rd_data[4]);
endmodule : sba_alarm_checker

bind sba_alarm_unit sba_alarm_checker u_checker (.sys_clk(sys_clk), .rstn(rstn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .rec_start(rec_start), .rec_end(rec_end), .bin_valid(bin_valid), .bin_in(bin_in), .active_rate(active_rate),
    .meas_in(meas_in), .cmd_in(cmd_in), .aux_output_one(aux_output_one), .aux_output_two(aux_output_two),
    .record_alarm(record_alarm));

// >>> dv/testbench.sv
// self-checking testbench for the spectral band alarm unit
// assumes the register offsets of sba_defs.svh and the unit's hand-over timing
`timescale 1ns/1ps
`include "sba_defs.svh"

module testbench;
    import sba_pkg::*;
    logic sys_clk, rstn, reg_wr_en, reg_rd_en, rec_start, rec_end, bin_valid;
    logic [6:0] reg_addr;
    logic [7:0] reg_wr_data;
    logic [15:0] reg_rd_data, rd_val;
    sba_bin_t bin_in, qb, xb;
    logic [1:0] active_rate;
    sba_meas_t meas_in;
    sba_cmd_t cmd_in;
    logic aux_output_one, aux_output_two, record_alarm, ra_seen, sys_exp;
    logic [11:0] sv;
    logic [6:0] zofs [6] = '{`SBA_OFS_F_LOW, `SBA_OFS_X_WARN, `SBA_OFS_PNTR, `SBA_OFS_X_STAT, `SBA_OFS_Z_PEAK, `SBA_OFS_Y_BIN};
    int bad_count;
    int total_checks;

    sba_alarm_unit dut (.sys_clk(sys_clk), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .rec_start(rec_start),
        .rec_end(rec_end), .bin_valid(bin_valid), .bin_in(bin_in), .active_rate(active_rate), .meas_in(meas_in),
        .cmd_in(cmd_in), .aux_output_one(aux_output_one), .aux_output_two(aux_output_two),
        .record_alarm(record_alarm));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1

    // word written as low byte then high byte
    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= v[7:0];
        @(posedge sys_clk);
        reg_addr <= a | 7'h01;
        reg_wr_data <= v[15:8];
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask : wr16

    task automatic rdchk(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        @(posedge sys_clk);
        #1 chk16(reg_rd_data & m, e);
    endtask : rdchk

    task automatic pulse_cmd(input sba_cmd_t c);
        @(posedge sys_clk);
        cmd_in <= c;
        @(posedge sys_clk);
        cmd_in <= 3'b000;
    endtask : pulse_cmd

    // one record of two bins; record_alarm sampled in its pulse cycle, indicators a cycle later
    task automatic rec(input logic [1:0] rate, input sba_bin_t b0, input sba_bin_t b1);
        @(posedge sys_clk);
        active_rate <= rate;
        rec_start <= 1'b1;
        @(posedge sys_clk);
        rec_start <= 1'b0;
        @(posedge sys_clk);
        bin_valid <= 1'b1;
        bin_in <= b0;
        @(posedge sys_clk);
        bin_in <= b1;
        @(posedge sys_clk);
        bin_valid <= 1'b0;
        @(posedge sys_clk);
        rec_end <= 1'b1;
        @(posedge sys_clk);
        rec_end <= 1'b0;
        #1 ra_seen = record_alarm;
        @(posedge sys_clk);
        #1;
    endtask : rec

    task automatic sys_step(input logic [15:0] c);
        wr16(`SBA_OFS_CFG, c);
        @(posedge sys_clk);
        meas_in.valid <= 1'b1;
        @(posedge sys_clk);
        meas_in.valid <= 1'b0;
        rec(2'd0, qb, qb);
    endtask : sys_step

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // hang guard
    initial begin
        repeat (50000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        {rstn, reg_wr_en, reg_rd_en, rec_start, rec_end, bin_valid, reg_addr, reg_wr_data} = '0;
        bin_in = '0;
        active_rate = 2'd0;
        meas_in = {1'b0, 12'h900, 12'h100};
        cmd_in = 3'b000;
        qb = {8'h15, 48'h0};
        xb = {8'h15, 16'h0250, 16'h0250, 16'h0150};
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        // reset values and access kinds
        rdchk(`SBA_OFS_CFG, 16'h0080);
        foreach (zofs[i]) rdchk(zofs[i], 16'h0000);
        wr16(`SBA_OFS_PNTR, 16'hffff);
        rdchk(`SBA_OFS_PNTR, 16'h0307);
        wr16(`SBA_OFS_CFG, 16'hffff);
        rdchk(`SBA_OFS_CFG, 16'h0fff);
        wr16(`SBA_OFS_X_STAT, 16'hffff);
        rdchk(`SBA_OFS_X_STAT, 16'h0000);
        // band 1 limits at rates 0 and 1, then thresholds
        wr16(`SBA_OFS_PNTR, 16'h0001);
        wr16(`SBA_OFS_F_LOW, 16'hff10);
        wr16(`SBA_OFS_F_HIGH, 16'h0020);
        wr16(`SBA_OFS_PNTR, 16'h0101);
        wr16(`SBA_OFS_F_LOW, 16'h0030);
        wr16(`SBA_OFS_F_HIGH, 16'h0040);
        wr16(`SBA_OFS_PNTR, 16'h0001);
        rdchk(`SBA_OFS_F_LOW, 16'h0010);
        for (int i = 0; i < 3; i++) begin
            wr16(`SBA_OFS_X_WARN + 7'(2 * i), 16'h0100);
            wr16(`SBA_OFS_X_FAULT + 7'(2 * i), 16'h0200);
        end
        rdchk(`SBA_OFS_Z_FAULT, 16'h0200);
        pulse_cmd(3'b001);
        // warning on x, fault on y, out-of-band bin ignored
        wr16(`SBA_OFS_CFG, 16'h0047);
        rec(2'd0, {8'h15, 16'h0050, 16'h0250, 16'h0150}, {8'h30, 48'hffff_ffff_ffff});
        chk1(ra_seen, 1'b1);
        chk1(aux_output_one, 1'b1);
        chk1(aux_output_two, 1'b1);
        rdchk(`SBA_OFS_X_STAT, 16'h0011);
        rdchk(`SBA_OFS_Y_STAT, 16'h0031);
        rdchk(`SBA_OFS_Z_STAT, 16'h0000);
        rdchk(`SBA_OFS_X_PEAK, 16'h0150);
        rdchk(`SBA_OFS_Y_BIN, 16'h0015);
        // rate 1 limits select the other bin; indicators off
        wr16(`SBA_OFS_CFG, 16'h0007);
        rec(2'd1, {8'h15, 16'h0050, 16'h0250, 16'h0150}, {8'h30, 48'hffff_ffff_ffff});
        chk1(aux_output_one, 1'b0);
        rdchk(`SBA_OFS_X_STAT, 16'h0031);
        // response delay 2 on x only
        wr16(`SBA_OFS_CFG, 16'h0241);
        rec(2'd0, qb, qb);
        chk1(ra_seen, 1'b0);
        for (int k = 0; k < 3; k++) begin
            rec(2'd0, xb, xb);
            rdchk(`SBA_OFS_X_STAT, (k == 2) ? 16'h0011 : 16'h0000);
            chk1(aux_output_one, k == 2);
            chk1(aux_output_two, 1'b0);
        end
        rdchk(`SBA_OFS_Y_STAT, 16'h0000);
        rec(2'd0, qb, qb);
        rdchk(`SBA_OFS_X_STAT, 16'h0000);
        // second save ignored until settings cleared
        wr16(`SBA_OFS_F_LOW, 16'h0000);
        wr16(`SBA_OFS_F_HIGH, 16'h0005);
        pulse_cmd(3'b001);
        wr16(`SBA_OFS_CFG, 16'h0041);
        rec(2'd0, xb, qb);
        rdchk(`SBA_OFS_X_STAT, 16'h0011);
        pulse_cmd(3'b010);
        wr16(`SBA_OFS_F_LOW, 16'h0000);
        wr16(`SBA_OFS_F_HIGH, 16'h0005);
        pulse_cmd(3'b001);
        rec(2'd0, {8'h15, 32'h0, 16'h0180}, {8'h03, 32'h0, 16'h0150});
        rdchk(`SBA_OFS_X_STAT, 16'h0011);
        rdchk(`SBA_OFS_X_BIN, 16'h0003);
        // system alarm source and polarity
        wr16(`SBA_OFS_SYS_LVL, 16'h0800);
        for (int i = 0; i < 4; i++) begin
            sv = i[0] ? 12'h900 : 12'h100;
            sys_exp = i[1] ? (sv < 12'h800) : (sv > 12'h800);
            sys_step(16'h0008 | 16'(i << 4));
            rdchk(`SBA_OFS_DIAG, {4'h0, sys_exp, 11'h000}, 16'h0800);
        end
        // latched flag survives until clear-status
        sys_step(16'h0098);
        sys_step(16'h00b8);
        rdchk(`SBA_OFS_DIAG, 16'h0800, 16'h0800);
        pulse_cmd(3'b100);
        rdchk(`SBA_OFS_DIAG, 16'h0000, 16'h0800);
        complete_run();
    end
endmodule : testbench
